/* File: test/modbus_register_encoding_test.sv */
// Self-checking bench for the parameter register bank
`timescale 1ns/1ps
`default_nettype none
module modbus_register_encoding_test;
  import mrb_pkg::*;
  // Text with an early null and junk after it
  localparam logic [127:0] TXT = 128'h4142_4300_5A5A_5A5A_5A5A_5A5A_5A5A_5A5A;
  logic clk_sys, sys_rst, wr, rd, pcs_on, acc_tick;
  logic wr_ack, blk_err, nv_save;
  logic [15:0] addr, wdata, rdata, ctrl_out, cfg_out, scale_out, nv_data;
  logic [15:0] meas_s16, d, d2, es;
  logic [31:0] meas_s32, v, seed;
  logic [63:0] meas_u64;
  logic [14:0] alarm_bits;
  logic [15:0] sc [5];
  int error_cnt, compares;
  mrb_regbank #(.TEXT_VAL(TXT)) u_mrb_regbank (.CLK_SYS(clk_sys),
    .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .WR_ACK(wr_ack), .BLK_ERR(blk_err), .PCS_ON(pcs_on),
    .ACC_TICK(acc_tick), .MEAS_S16(meas_s16), .MEAS_S32(meas_s32),
    .MEAS_U64(meas_u64), .ALARM_BITS(alarm_bits), .CTRL_OUT(ctrl_out),
    .CFG_OUT(cfg_out), .SCALE_OUT(scale_out), .NV_SAVE(nv_save),
    .NV_DATA(nv_data));
  mrb_client u_mrb_client (.CLK_SYS(clk_sys), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Most negative code reads as the most negative valid value
  function automatic logic [15:0] exp_s16(input logic [15:0] x);
    return (x == NI_SIGNED) ? S16_MIN_VALID : x;
  endfunction
  function automatic logic [31:0] exp_s32(input logic [31:0] x);
    return (x == S32_NI) ? S32_MIN_VALID : x;
  endfunction
  function automatic logic [15:0] exp_txt(input int i);
    logic [127:0] t;
    logic z;
    t = TXT;
    z = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      if (t[127-8*k -: 8] == 8'h00)
        z = 1'b1;
      if (z)
        t[127-8*k -: 8] = 8'h00;
    end
    return t[127-16*i -: 16];
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] x);
    u_mrb_client.wr(a + REG_NUM_BASE, x);
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] x);
    u_mrb_client.rd(a + REG_NUM_BASE, x);
  endtask
  task automatic rd2_reg(input logic [15:0] a, output logic [15:0] x,
    output logic [15:0] y);
    u_mrb_client.rd2(a + REG_NUM_BASE, x, y);
  endtask
  // Run takes under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    sys_rst = 1'b1;
    pcs_on = 1'b0;
    acc_tick = 1'b0;
    meas_s16 = 16'h0000;
    meas_s32 = 32'h0000_0000;
    meas_u64 = 64'h0000_0000_0000_0000;
    alarm_bits = 15'h0000;
    seed = 32'h0000_89B8;
    sc = '{16'h000A, 16'hFFF6, 16'h000B, 16'hFFF5, 16'h8000};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_reg(A_PAD, d);
    check(d, PAD_VALUE);
    // Read data stand one cycle only and fall back to zero
    @(posedge clk_sys);
    #1;
    check(rdata, NI_ZERO);
    check({ctrl_out, cfg_out, scale_out}, 48'h0);
    // Low half returns the snapshot, so the high half goes first
    rd_reg(A_ACC_HI, d);
    check(d, ACC_RST[31:16]);
    rd_reg(A_ACC_LO, d);
    check(d, ACC_RST[15:0]);
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      wr_reg(A_CTRL, seed[15:0]);
      check({wr_ack, ctrl_out}, {1'b1, seed[15:0]});
      rd_reg(A_CTRL, d);
      check(d, seed[15:0]);
    end
    wr_reg(A_CFG, 16'h1234);
    check({nv_save, cfg_out, nv_data}, {1'b1, 32'h1234_1234});
    @(posedge clk_sys);
    pcs_on <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr_reg(A_CFG, 16'h5678);
    check({wr_ack, nv_save, cfg_out}, {2'b10, 16'h1234});
    pcs_on <= 1'b0;
    es = SCALE_RST;
    foreach (sc[k])
    begin
      wr_reg(A_SCALE, sc[k]);
      if ($signed(sc[k]) >= SCALE_MIN && $signed(sc[k]) <= SCALE_MAX)
        es = sc[k];
      check(scale_out, es);
    end
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      v = (i == 0) ? S32_NI : xs(seed);
      @(posedge clk_sys);
      meas_s16 <= (i == 0) ? NI_SIGNED : seed[15:0];
      meas_s32 <= v;
      meas_u64 <= {seed, ~v};
      alarm_bits <= v[14:0];
      rd_reg(A_MEAS16, d);
      check(d, exp_s16((i == 0) ? NI_SIGNED : seed[15:0]));
      rd_reg(A_ALARM, d);
      check(d, {1'b0, v[14:0]});
      rd_reg(A_S32_HI, d);
      check(d, exp_s32(v) >> 16);
      meas_s32 <= ~v;
      rd_reg(A_S32_LO, d);
      check(d, exp_s32(v) & 32'h0000_FFFF);
      for (int k = 0; k < 4; k++)
      begin
        rd_reg(A_U64_0 + 16'(k), d);
        check(d, {seed, ~v} >> (48 - 16 * k) & 64'hFFFF);
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      rd_reg(A_TEXT_0 + 16'(k), d);
      check(d, exp_txt(k));
      rd_reg(A_UTXT_0 + 16'(k), d);
      check(d, NI_ZERO);
    end
    rd_reg(A_UACC_0, d);
    check(d, NI_ZERO);
    rd_reg(A_USGN, d);
    check(d, NI_SIGNED);
    rd_reg(16'h0100, d);
    check(d, NI_UNSIGNED);
    @(posedge clk_sys);
    acc_tick <= 1'b1;
    repeat (5) @(posedge clk_sys);
    acc_tick <= 1'b0;
    // High and low halves read back to back, as a block read would
    rd2_reg(A_ACC_HI, d, d2);
    check(d, 16'h0000);
    check(d2, ACC_RST[15:0] + ACC_STEP[15:0]);
    for (int k = 0; k < 125; k++)
    begin
      wr_reg(16'h0200 + 16'(k), 16'(k));
      check({wr_ack, blk_err}, {1'b1, k == 123});
    end
    finish_test();
  end
endmodule
`default_nettype wire

/* File: test/mrb_client.sv */
// Register port client model issuing single writes and single or back-to-back reads
`timescale 1ns/1ps
`default_nettype none
module mrb_client
  import mrb_pkg::*;
(
  // Clock
  input wire logic CLK_SYS,
  // Register port
  output logic [15:0] ADDR,
  output logic [15:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [15:0] RDATA
);
  initial
  begin
    ADDR = 16'h0000;
    WDATA = 16'h0000;
    WR = 1'b0;
    RD = 1'b0;
  end
  // Takes register numbers; runs of writes are not capped, and the bench drives a run of 125 registers
  // and writes the nonvolatile configuration word twice, not cyclically
  task automatic wr(input logic [15:0] num, input logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= num - REG_NUM_BASE;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    // Data no longer qualified: scramble so a stale value cannot pass
    WDATA <= ~d;
    #1;
  endtask
  task automatic rd(input logic [15:0] num, output logic [15:0] d);
    @(posedge CLK_SYS);
    ADDR <= num - REG_NUM_BASE;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  // Two reads with no gap, the second at the next register
  task automatic rd2(input logic [15:0] num, output logic [15:0] d0,
    output logic [15:0] d1);
    @(posedge CLK_SYS);
    ADDR <= num - REG_NUM_BASE;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    ADDR <= num - REG_NUM_BASE + 16'h0001;
    #1;
    d0 = RDATA;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    d1 = RDATA;
  endtask
endmodule
`default_nettype wire

/* File: verilog/mrb_pkg.sv */
// Constants for the parameter register bank: map, codes, limits and resets
package mrb_pkg;
  // Address on the bus is the one-based register number minus this base
  localparam logic [15:0] REG_NUM_BASE = 16'h0001;
  // Register addresses (zero based)
  localparam logic [15:0] A_CTRL = 16'h0000;
  localparam logic [15:0] A_CFG = 16'h0001;
  localparam logic [15:0] A_SCALE = 16'h0002;
  localparam logic [15:0] A_MEAS16 = 16'h0003;
  localparam logic [15:0] A_ALARM = 16'h0004;
  localparam logic [15:0] A_ACC_HI = 16'h0005;
  localparam logic [15:0] A_ACC_LO = 16'h0006;
  localparam logic [15:0] A_S32_HI = 16'h0007;
  localparam logic [15:0] A_S32_LO = 16'h0008;
  localparam logic [15:0] A_U64_0 = 16'h0009;
  localparam logic [15:0] A_U64_3 = 16'h000C;
  localparam logic [15:0] A_TEXT_0 = 16'h000D;
  localparam logic [15:0] A_TEXT_7 = 16'h0014;
  localparam logic [15:0] A_PAD = 16'h0015;
  localparam logic [15:0] A_UACC_0 = 16'h0016;
  localparam logic [15:0] A_UACC_1 = 16'h0017;
  localparam logic [15:0] A_USGN = 16'h0018;
  localparam logic [15:0] A_UTXT_0 = 16'h0019;
  localparam logic [15:0] A_UTXT_7 = 16'h0020;
  // Not-implemented and fixed read codes
  localparam logic [15:0] NI_UNSIGNED = 16'hFFFF;
  localparam logic [15:0] NI_SIGNED = 16'h8000;
  localparam logic [15:0] NI_ZERO = 16'h0000;
  localparam logic [15:0] PAD_VALUE = 16'h8000;
  localparam logic [15:0] S16_MIN_VALID = 16'h8001;
  localparam logic [31:0] S32_NI = 32'h8000_0000;
  localparam logic [31:0] S32_MIN_VALID = 32'h8000_0001;
  // Scale exponent limits
  localparam logic signed [15:0] SCALE_MIN = -16'sd10;
  localparam logic signed [15:0] SCALE_MAX = 16'sd10;
  // Reset values and accumulator step
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] SCALE_RST = 16'h0000;
  localparam logic [31:0] ACC_RST = 32'h0000_0001;
  localparam logic [31:0] ACC_STEP = 32'h0000_0001;
  // Block write limit
  localparam logic [7:0] BLK_MAX = 8'h7B;
  localparam logic [7:0] BLK_ONE = 8'h01;
endpackage

/* File: verilog/mrb_regbank.sv */
// Parameter register bank with typed encodings and not-implemented codes
//
// Contract
// - Bus address equals register number minus one
// - Writable registers store, readable registers return
// - Run-locked writes ignored while converter on
// - Configuration writes go to nonvolatile storage
// - Cyclic-safe registers take periodic writes freely
// - Unsigned word: one big-endian register
// - Signed word range +-32767, 0x8000 not implemented
// - Unsigned dword: two registers, high first
// - Signed dword big-endian, 0x80000000 not implemented
// - Unsigned qword: four registers, high first
// - Text two chars per register, null padded
// - Unimplemented text reads all zeros
// - Unimplemented registers return per-format code
// - Pad register always reads 0x8000
// - Accumulator only increases, wraps, never zero
// - Scale exponent held within -10 to 10
// - Bitfield most significant bit kept clear
// - Write acknowledged only after register updated (WR_ACK follows every WR, so locked and dropped writes are acked too)
// - Block writes contiguous, 1 to 123 registers
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mrb_regbank
#(
  parameter logic [127:0] TEXT_VAL = 128'h4445_5649_4345_0000_0000_0000_0000_0000
)
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic WR_ACK,
  output logic BLK_ERR,
  // Converter pins
  input wire logic PCS_ON,
  input wire logic ACC_TICK,
  // Measured values from the converter logic
  input wire logic [15:0] MEAS_S16,
  input wire logic [31:0] MEAS_S32,
  input wire logic [63:0] MEAS_U64,
  input wire logic [14:0] ALARM_BITS,
  // Settings toward the converter and the nonvolatile store
  output logic [15:0] CTRL_OUT,
  output logic [15:0] CFG_OUT,
  output logic [15:0] SCALE_OUT,
  output logic NV_SAVE,
  output logic [15:0] NV_DATA
);
  import mrb_pkg::*;

  logic on_s1_ff, on_s2_ff;
  logic tick_s1_ff, tick_s2_ff, tick_s3_ff;
  logic [15:0] ctrl_ff, cfg_ff, scale_ff;
  logic [31:0] acc_ff, nxt_acc;
  logic [63:0] snap_ff;
  logic [15:0] rdata_ff, nxt_rdata;
  logic ack_ff, nv_save_ff, blk_err_ff;
  logic [15:0] nv_data_ff;
  logic [15:0] last_addr_ff;
  logic [7:0] blk_cnt_ff, nxt_blk_cnt;
  logic [15:0] meas16_c;
  logic [31:0] meas32_c;
  logic [127:0] text_c;
  logic scale_ok;

  // Pins cross in from outside the clock domain
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      on_s1_ff <= 1'b0;
      on_s2_ff <= 1'b0;
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
      tick_s3_ff <= 1'b0;
    end
    else
    begin
      on_s1_ff <= PCS_ON;
      on_s2_ff <= on_s1_ff;
      tick_s1_ff <= ACC_TICK;
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end

  // Immediate control word, volatile so cyclic rewrites cost nothing
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      ctrl_ff <= CTRL_RST;
    else if (WR && ADDR == A_CTRL)
      ctrl_ff <= WDATA;
  end

  // Configuration word: locked while running, copied to the NV store
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      cfg_ff <= CFG_RST;
      nv_save_ff <= 1'b0;
      nv_data_ff <= CFG_RST;
    end
    else
    begin
      nv_save_ff <= 1'b0;
      if (WR && ADDR == A_CFG && !on_s2_ff)
      begin
        cfg_ff <= WDATA;
        nv_save_ff <= 1'b1;
        nv_data_ff <= WDATA;
      end
    end
  end

  // Out-of-range exponents are dropped rather than clamped
  assign scale_ok = ($signed(WDATA) >= SCALE_MIN)
                 && ($signed(WDATA) <= SCALE_MAX);

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      scale_ff <= SCALE_RST;
    else if (WR && ADDR == A_SCALE && scale_ok)
      scale_ff <= WDATA;
  end

  // Accumulator skips zero on wrap, since zero means not implemented
  always_comb
  begin
    nxt_acc = acc_ff + ACC_STEP;
    if (nxt_acc == 32'h0000_0000)
      nxt_acc = ACC_RST;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      acc_ff <= ACC_RST;
    else if (tick_s2_ff && !tick_s3_ff)
      acc_ff <= nxt_acc;
  end

  // The reserved most negative codes are never shown as live data
  assign meas16_c = (MEAS_S16 == NI_SIGNED) ? S16_MIN_VALID : MEAS_S16;
  assign meas32_c = (MEAS_S32 == S32_NI) ? S32_MIN_VALID : MEAS_S32;

  // Everything after the first null byte reads as zero
  function automatic logic [127:0] text_pad(input logic [127:0] t);
    logic seen;
    text_pad = t;
    seen = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (t[i*8 +: 8] == 8'h00)
        seen = 1'b1;
      if (seen)
        text_pad[i*8 +: 8] = 8'h00;
    end
  endfunction

  assign text_c = text_pad(TEXT_VAL);

  // Snapshot on the first register of each multi-register group
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      snap_ff <= '0;
    else if (RD)
    begin
      if (ADDR == A_ACC_HI)
        snap_ff <= {32'h0000_0000, acc_ff};
      else if (ADDR == A_S32_HI)
        snap_ff <= {32'h0000_0000, meas32_c};
      else if (ADDR == A_U64_0)
        snap_ff <= MEAS_U64;
    end
  end

  // Read decode; high byte on RDATA[15:8] gives big-endian order
  always_comb
  begin
    logic [15:0] off;
    off = ADDR - A_TEXT_0;
    nxt_rdata = NI_UNSIGNED;
    if (ADDR >= A_TEXT_0 && ADDR <= A_TEXT_7)
      nxt_rdata = text_c[(8'd7 - off[7:0]) * 16 +: 16];
    else if (ADDR >= A_UTXT_0 && ADDR <= A_UTXT_7)
      nxt_rdata = NI_ZERO;
    else if (ADDR > A_U64_0 && ADDR <= A_U64_3)
      nxt_rdata = snap_ff[(A_U64_3 - ADDR) * 16 +: 16];
    else
    begin
      // Decode is on the zero-based bus address, so register one is 0
      case (ADDR)
        A_CTRL: nxt_rdata = ctrl_ff;
        A_CFG: nxt_rdata = cfg_ff;
        A_SCALE: nxt_rdata = scale_ff;
        A_MEAS16: nxt_rdata = meas16_c;
        A_ALARM: nxt_rdata = {1'b0, ALARM_BITS};
        A_ACC_HI: nxt_rdata = acc_ff[31:16];
        A_ACC_LO: nxt_rdata = snap_ff[15:0];
        A_S32_HI: nxt_rdata = meas32_c[31:16];
        A_S32_LO: nxt_rdata = snap_ff[15:0];
        A_U64_0: nxt_rdata = MEAS_U64[63:48];
        A_PAD: nxt_rdata = PAD_VALUE;
        A_UACC_0, A_UACC_1: nxt_rdata = NI_ZERO;
        A_USGN: nxt_rdata = NI_SIGNED;
        default: nxt_rdata = NI_UNSIGNED;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      rdata_ff <= NI_ZERO;
    else if (RD)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= NI_ZERO;
  end

  // Ack rises on the same edge that stores the data, so it never leads it
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      ack_ff <= 1'b0;
    else
      ack_ff <= WR;
  end

  // A run of writes at consecutive rising addresses is one block, capped in length
  always_comb
  begin
    if (blk_cnt_ff != 8'h00 && ADDR == last_addr_ff + REG_NUM_BASE)
      nxt_blk_cnt = blk_cnt_ff + BLK_ONE;
    else
      nxt_blk_cnt = BLK_ONE;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      blk_cnt_ff <= 8'h00;
      last_addr_ff <= 16'h0000;
      blk_err_ff <= 1'b0;
    end
    else
    begin
      blk_err_ff <= 1'b0;
      if (WR)
      begin
        last_addr_ff <= ADDR;
        blk_cnt_ff <= (nxt_blk_cnt > BLK_MAX) ? BLK_ONE : nxt_blk_cnt;
        blk_err_ff <= (nxt_blk_cnt > BLK_MAX);
      end
    end
  end

  assign RDATA = rdata_ff;
  assign WR_ACK = ack_ff;
  assign BLK_ERR = blk_err_ff;
  assign CTRL_OUT = ctrl_ff;
  assign CFG_OUT = cfg_ff;
  assign SCALE_OUT = scale_ff;
  assign NV_SAVE = nv_save_ff;
  assign NV_DATA = nv_data_ff;

  sequence wr_cfg_s;
    WR && ADDR == A_CFG;
  endsequence

  sequence wr_ctrl_s;
    WR && ADDR == A_CTRL;
  endsequence

  ack_after_write_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) wr_ctrl_s |=> WR_ACK && CTRL_OUT == $past(WDATA))
    else $error("write ack without updated register");

  run_lock_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) wr_cfg_s ##0 on_s2_ff
      |=> CFG_OUT == $past(CFG_OUT) && !NV_SAVE)
    else $error("locked register changed while running");

  nv_store_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) wr_cfg_s ##0 !on_s2_ff
      |=> NV_SAVE && NV_DATA == $past(WDATA))
    else $error("config write not sent to store");

  scale_range_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST)
      $signed(SCALE_OUT) >= SCALE_MIN && $signed(SCALE_OUT) <= SCALE_MAX)
    else $error("scale exponent out of range");

  pad_read_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) RD && ADDR == A_PAD |=> RDATA == PAD_VALUE)
    else $error("pad register not 0x8000");

  unimpl_read_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) RD && ADDR > A_UTXT_7 |=> RDATA == NI_UNSIGNED)
    else $error("unmapped register not all ones");

  acc_nonzero_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) acc_ff != 32'h0000_0000 && acc_ff >= $past(acc_ff)
      || $past(acc_ff) == 32'hFFFF_FFFF)
    else $error("accumulator zero or decreasing");

  signed_read_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) RD && ADDR == A_MEAS16 |=> RDATA != NI_SIGNED)
    else $error("reserved signed code on live data");

  bitfield_msb_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) RD && ADDR == A_ALARM |=> !RDATA[15])
    else $error("bitfield msb set");

  snapshot_a: assert property (@(posedge CLK_SYS)
    disable iff (SYS_RST) RD && ADDR == A_ACC_HI ##1 RD && ADDR == A_ACC_LO
      |=> RDATA == $past(acc_ff[15:0], 2))
    else $error("accumulator read torn");
endmodule
`default_nettype wire
